// [logic/swp_defines.svh]
// constants for the subtract alu and wake path slice
// assumes inclusion by the core and the testbench files
`ifndef SWP_DEFINES_SVH
`define SWP_DEFINES_SVH
`define SWP_ADDR_CTRL 12'h000
`define SWP_ADDR_INSTR 12'h004
`define SWP_ADDR_ACC 12'h008
`define SWP_ADDR_STATUS 12'h00c
`define SWP_ADDR_PC 12'h010
`define SWP_ADDR_FILE 12'h200
`define SWP_OPC_LIT 5'h1e
`define SWP_OPC_REG 6'h02
`define SWP_IRQ_VECTOR 13'h0004
`define SWP_CTRL_GIE_BIT 0
`define SWP_CTRL_SLEEP_BIT 1
`define SWP_CTRL_WAKE_BIT 2
`define SWP_STAT_C_BIT 0
`define SWP_STAT_DC_BIT 1
`define SWP_STAT_Z_BIT 2
`define SWP_STAT_SLEEP_BIT 3
`define SWP_STAT_PEND_BIT 4
`define SWP_RESET_ACC 8'h00
`define SWP_RESET_PC 13'h0000
`endif

// [logic/swp_pkg.sv]
// types for the subtract alu and wake path slice
// assumes nothing beyond the defines header
package swp_pkg;
   typedef struct packed {
      logic [7:0] result;
      logic carry;
      logic digit_carry_flag;
      logic zero;
   } swp_alu_out_type;

   typedef enum logic [2:0] {
      swp_run = 3'b001,
      swp_asleep = 3'b010,
      swp_vector = 3'b100
   } swp_state_type;

   typedef struct packed {
      swp_state_type state;
      logic [7:0] acc;
      logic carry;
      logic digit_carry_flag;
      logic zero;
      logic global_irq_enable;
      logic [12:0] pc;
      logic [31:0] prdata;
   } swp_regs_type;
endpackage

// [logic/swp_sub_unit.sv]
// subtractor: minuend minus subtrahend with borrow-style flags
// assumes purely combinational use by the core slice
`timescale 1ns/1ps
`default_nettype none
module swp_sub_unit #(
   parameter int WIDTH = 8
) (
   input wire logic [WIDTH-1:0] minuend,
   input wire logic [WIDTH-1:0] subtrahend,
   output var swp_pkg::swp_alu_out_type res
);
   initial begin
      if (WIDTH != 8) $error("swp_sub_unit supports width 8 only");
   end
   logic [8:0] full;
   logic [4:0] low;
   // two's complement: add inverted subtrahend plus one
   assign full = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
   assign low = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
   // result, carry as no borrow, nibble carry, zero
   assign res = {full[7:0], full[8], low[4], full[7:0] == 8'h00};
endmodule // swp_sub_unit
`default_nettype wire

// [logic/swp_core.sv]
// subtract alu and wake path slice, registers over apb
// assumes apb master on pclk, one instruction per apb write
//
// Operation
// - literal minus accumulator goes to accumulator
// - decode literal subtract from 11110x prefix
// - decode register subtract, seven-bit file address
// - destination bit picks accumulator or file
// - set carry and zero, carry means no borrow
// - wake branches only with global enable set
// - run next instruction, then vector 0004h
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "swp_defines.svh"
module swp_core #(
   parameter int FILE_DEPTH = 128
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic wake_irq,
   output logic [12:0] pc,
   output logic asleep
);
   initial begin
      if (FILE_DEPTH != 128) $error("swp_core needs a 128-entry file");
   end

   // ************
   // state
   // ************
   swp_pkg::swp_regs_type r, next_r;
   logic [7:0] file_mem [0:127];
   logic wake_pend, next_wake_pend;

   logic wr, rd;
   logic [13:0] instr;
   logic is_lit, is_reg, is_file_addr;
   logic [6:0] faddr;
   logic [7:0] fval, minuend;
   logic file_we;
   logic [6:0] file_wa;
   logic [7:0] file_wd;
   swp_pkg::swp_alu_out_type alu;

   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign instr = pwdata[13:0];
   assign is_lit = wr && paddr == `SWP_ADDR_INSTR && instr[13:9] == `SWP_OPC_LIT;
   assign is_reg = wr && paddr == `SWP_ADDR_INSTR && instr[13:8] == `SWP_OPC_REG;
   assign is_file_addr = paddr[11:9] == 3'h1 && paddr[8:2] <= 7'h7f && paddr[1:0] == 2'h0;
   assign faddr = is_reg ? instr[6:0] : paddr[8:2];
   assign fval = file_mem[faddr];
   assign minuend = is_lit ? instr[7:0] : fval;

   swp_sub_unit #(
      .WIDTH(8)
   ) u_sub (
      .minuend(minuend),
      .subtrahend(r.acc),
      .res(alu)
   );

   // ************
   // next state
   // ************
   always_comb begin
      next_r = r;
      next_wake_pend = wake_pend;
      file_we = 1'b0;
      file_wa = faddr;
      file_wd = alu.result;
      if (is_lit || is_reg) begin
         next_r.carry = alu.carry;
         next_r.digit_carry_flag = alu.digit_carry_flag;
         next_r.zero = alu.zero;
         if (is_lit || !instr[7]) begin
            next_r.acc = alu.result;
         end else begin
            file_we = 1'b1;
         end
      end
      if (wr && paddr == `SWP_ADDR_ACC) next_r.acc = pwdata[7:0];
      if (wr && is_file_addr) begin
         file_we = 1'b1;
         file_wd = pwdata[7:0];
      end
      if (wr && paddr == `SWP_ADDR_CTRL) begin
         next_r.global_irq_enable = pwdata[`SWP_CTRL_GIE_BIT];
      end
      unique case (r.state)
         swp_pkg::swp_run: begin
            if ((is_lit || is_reg) && wake_pend) begin
               next_r.state = swp_pkg::swp_vector;
               next_wake_pend = 1'b0;
            end else if (is_lit || is_reg) begin
               next_r.pc = r.pc + 13'h0001;
            end
            if (wr && paddr == `SWP_ADDR_CTRL && pwdata[`SWP_CTRL_SLEEP_BIT]) begin
               next_r.state = swp_pkg::swp_asleep;
            end
         end
         swp_pkg::swp_asleep: begin
            if (wake_irq) begin
               next_r.state = swp_pkg::swp_run;
               next_wake_pend = r.global_irq_enable;
            end
         end
         swp_pkg::swp_vector: begin
            next_r.pc = `SWP_IRQ_VECTOR;
            next_r.global_irq_enable = 1'b0;
            next_r.state = swp_pkg::swp_run;
         end
      endcase
      next_r.prdata = 32'h0000_0000;
      if (rd) begin
         unique case (paddr)
            `SWP_ADDR_CTRL: next_r.prdata = {31'h0, r.global_irq_enable};
            `SWP_ADDR_ACC: next_r.prdata = {24'h0, r.acc};
            `SWP_ADDR_STATUS: next_r.prdata = {27'h0, wake_pend,
               r.state == swp_pkg::swp_asleep, r.zero, r.digit_carry_flag, r.carry};
            `SWP_ADDR_PC: next_r.prdata = {19'h0, r.pc};
            default: next_r.prdata = is_file_addr ? {24'h0, fval} : 32'h0;
         endcase
      end
   end

   // ************
   // registers
   // ************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{state: swp_pkg::swp_run, acc: `SWP_RESET_ACC, carry: 1'b0,
                digit_carry_flag: 1'b0, zero: 1'b0, global_irq_enable: 1'b0,
                pc: `SWP_RESET_PC, prdata: 32'h0};
         wake_pend <= 1'b0;
      end else begin
         r <= next_r;
         wake_pend <= next_wake_pend;
      end
   end

   always_ff @(posedge pclk) begin
      if (file_we) file_mem[file_wa] <= file_wd;
   end

   // read data appears in the access cycle's second edge: one wait state on reads
   logic rd_wait;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rd_wait <= 1'b0;
      else rd_wait <= rd & ~rd_wait;
   end
   assign pready = pwrite | rd_wait | ~psel;
   assign prdata = r.prdata;
   assign pslverr = 1'b0;
   assign pc = r.pc;
   assign asleep = r.state == swp_pkg::swp_asleep;

   // ************
   // checks
   // ************
   a_lit_result: assert property (@(posedge pclk) disable iff (!presetn)
      is_lit |=> r.acc == $past(instr[7:0]) - $past(r.acc))
      else $error("literal subtract result wrong");
   a_reg_acc: assert property (@(posedge pclk) disable iff (!presetn)
      (is_reg && !instr[7]) |=> r.acc == $past(fval) - $past(r.acc))
      else $error("register subtract to acc wrong");
   a_reg_keep: assert property (@(posedge pclk) disable iff (!presetn)
      (is_reg && instr[7] && !(wr && paddr == `SWP_ADDR_ACC)) |=> $stable(r.acc))
      else $error("acc changed on file destination");
   a_carry_flag: assert property (@(posedge pclk) disable iff (!presetn)
      is_lit |=> r.carry == ($past(instr[7:0]) >= $past(r.acc)))
      else $error("carry wrong");
   a_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
      is_lit |=> r.zero == (r.acc == 8'h00))
      else $error("zero wrong");
   a_digit_flag: assert property (@(posedge pclk) disable iff (!presetn)
      is_lit |=> r.digit_carry_flag == ($past(instr[3:0]) >= $past(r.acc[3:0])))
      else $error("digit carry wrong");
   a_wake_inline: assert property (@(posedge pclk) disable iff (!presetn)
      (asleep && wake_irq && !r.global_irq_enable) |=> !wake_pend)
      else $error("wake with enable clear must stay in line");
   a_vector_jump: assert property (@(posedge pclk) disable iff (!presetn)
      ((is_lit || is_reg) && wake_pend && r.state == swp_pkg::swp_run) |=> ##1 pc == 13'h0004)
      else $error("vector not taken");
   a_decode_reg: assert property (@(posedge pclk) disable iff (!presetn)
      is_reg |-> !is_lit)
      else $error("decode overlap");
   a_decode_lit: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == `SWP_ADDR_INSTR && instr[13:9] == 5'h1e) |-> is_lit)
      else $error("literal decode missed");
   a_pc_step: assert property (@(posedge pclk) disable iff (!presetn)
      ((is_lit || is_reg) && !wake_pend && r.state == swp_pkg::swp_run
       && !(wr && paddr == `SWP_ADDR_CTRL)) |=> pc == $past(pc) + 13'h0001)
      else $error("pc did not step after subtract");
   a_gie_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (r.state == swp_pkg::swp_vector) |=> !r.global_irq_enable)
      else $error("global enable not cleared on vector");
   a_read_wait: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && !rd_wait) |-> !pready)
      else $error("read answered without wait state");
   c_lit: cover property (@(posedge pclk) is_lit);
   c_reg_file: cover property (@(posedge pclk) is_reg && instr[7]);
   c_wake_vec: cover property (@(posedge pclk) r.state == swp_pkg::swp_vector);
   c_sleep: cover property (@(posedge pclk) asleep ##1 !asleep);
endmodule // swp_core
`default_nettype wire

// [testbench/subtract_alu_wake_path_tb.sv]
// testbench for the subtract alu and wake path slice
// assumes swp_core on pclk with apb access and the defines header
`timescale 1ns/1ps
`default_nettype none
`include "swp_defines.svh"
module subtract_alu_wake_path_tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, wake_irq = 1'b0, asleep;
   logic [12:0] pc, epc;
   int err_count = 0, cmp_count = 0, n;
   logic [31:0] v;
   swp_core swp_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wake_irq(wake_irq), .pc(pc), .asleep(asleep));
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   // ****************
   // tasks
   // ****************
   task automatic conclude();
      if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic run(input logic [13:0] ins, input logic [7:0] m, w, input logic isreg,
                      input logic tofile, input logic [11:0] fa);
      logic [7:0] r;
      r = m - w;
      if (isreg) apb(1'b1, fa, {24'h0, m}, v);
      apb(1'b1, `SWP_ADDR_ACC, {24'h0, w}, v);
      apb(1'b1, `SWP_ADDR_INSTR, {18'h0, ins}, v);
      epc = epc + 13'h0001;
      apb(1'b0, `SWP_ADDR_ACC, 32'h0, v);
      check(v, {24'h0, tofile ? w : r});
      if (isreg) apb(1'b0, fa, 32'h0, v);
      if (isreg) check(v, {24'h0, tofile ? r : m});
      apb(1'b0, `SWP_ADDR_STATUS, 32'h0, v);
      check({29'h0, v[2:0]}, {29'h0, r == 8'h00, m[3:0] >= w[3:0], m >= w});
   endtask
   task automatic doze(input logic en);
      apb(1'b1, `SWP_ADDR_CTRL, {30'h0, 1'b1, en}, v);
      @(posedge pclk);
      check({31'h0, asleep}, 32'h1);
      wake_irq <= 1'b1;
      n = 0;
      while (asleep === 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      wake_irq <= 1'b0;
      check({31'h0, asleep}, 32'h0);
      run(14'h3c05, 8'h05, 8'h03, 1'b0, 1'b0, 12'h000);
      repeat (3) @(posedge pclk);
      if (en) epc = `SWP_IRQ_VECTOR;
      check({19'h0, pc}, {19'h0, epc});
      apb(1'b0, `SWP_ADDR_CTRL, 32'h0, v);
      check({31'h0, v[0]}, 32'h0);
   endtask
   // ****************
   // main sequence
   // ****************
   initial begin
      #100000;
      err_count++;
      conclude();
   end
   initial begin
      epc = 13'h0000;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      check({19'h0, pc}, 32'h0);
      run(14'h3c02, 8'h02, 8'h01, 1'b0, 1'b0, 12'h000);
      run(14'h3d02, 8'h02, 8'h02, 1'b0, 1'b0, 12'h000);
      run(14'h3c02, 8'h02, 8'h03, 1'b0, 1'b0, 12'h000);
      run(14'h3d10, 8'h10, 8'h01, 1'b0, 1'b0, 12'h000);
      run(14'h3dff, 8'hff, 8'h80, 1'b0, 1'b0, 12'h000);
      run(14'h0285, 8'h03, 8'h02, 1'b1, 1'b1, 12'h214);
      run(14'h02ff, 8'h01, 8'h02, 1'b1, 1'b1, 12'h3fc);
      run(14'h0240, 8'h02, 8'h02, 1'b1, 1'b0, 12'h300);
      run(14'h0200, 8'h20, 8'h21, 1'b1, 1'b0, 12'h200);
      check({19'h0, pc}, {19'h0, epc});
      apb(1'b1, `SWP_ADDR_INSTR, 32'h0000_0100, v);
      check({19'h0, pc}, {19'h0, epc});
      apb(1'b0, 12'h100, 32'h0, v);
      check(v, 32'h0);
      doze(1'b0);
      doze(1'b1);
      conclude();
   end
endmodule // subtract_alu_wake_path_tb
`default_nettype wire
